/* File: logic/sdwc_top.sv */
// power-down controller: key-protected shutdown command, debounced and alarm wake-up
// Notes on behaviour
// - runs on the one clock, never gated
// - keyed command with bit set asserts output
// - command reaches output two cycles later
// - wrong key discards the whole write
// - edge select: off, rise, fall, any
// - release after count*16+1 stable cycles
// - input change during debounce abandons it and returns to idle
// - input wake flag sticky, clears on read
// - enabled alarm rising edge releases output
// - enabled alarm edge sets flag, read clears
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sdwc_top (
	input  wire logic        clk_i,       // slow clock
	input  wire logic        rst_i,       // sync reset, active high
	input  wire logic        wb_cyc_i,    // wishbone cycle
	input  wire logic        wb_stb_i,    // wishbone strobe
	input  wire logic        wb_we_i,     // wishbone write
	input  wire logic [7:0]  wb_adr_i,    // byte address
	input  wire logic [3:0]  wb_sel_i,    // byte enables
	input  wire logic [31:0] wb_dat_i,    // write data
	output logic      [31:0] wb_dat_o,    // read data
	output logic             wb_ack_o,    // acknowledge
	output logic             wb_err_o,    // unmapped access
	input  wire logic        wake_input_pin_i, // wake-up input
	input  wire logic        alarm_i,     // alarm level, synchronous
	output logic             power_off_pin_o,  // shutdown output, high = off
	output logic             irq_o        // level interrupt
);
	import sdwc_pkg::*;

	// ==========================================================
	// bus decode
	logic        req;
	logic        hit;
	logic        wr;
	logic        rd_stat;
	sdwc_mode_t  mode;
	sdwc_mode_t  next_mode;
	logic [31:0] stat;
	logic [31:0] next_stat;
	logic [31:0] mask;
	logic [31:0] next_mask;
	logic [31:0] next_dat;
	logic        next_ack;
	logic        next_err;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// mode register as seen on the bus, unused bits read as zero
	function automatic logic [31:0] pack_mode(input sdwc_mode_t m);
		logic [31:0] r;
		r = 32'h0;
		r[SDWC_ALARM_BIT] = m.alarm_wake_enable;
		r[SDWC_DEB_LSB +: 4] = m.wake_debounce_count;
		r[SDWC_EDGE_LSB +: 2] = m.wake_edge_select;
		return r;
	endfunction

	logic [31:0] mode_wr;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit = (wb_adr_i == SDWC_CMD_OFF) || (wb_adr_i == SDWC_MODE_OFF)
		|| (wb_adr_i == SDWC_STAT_OFF) || (wb_adr_i == SDWC_MASK_OFF);
	assign wr = req && hit && wb_we_i;
	assign rd_stat = req && !wb_we_i && (wb_adr_i == SDWC_STAT_OFF);
	// byte lanes merged over the current mode word
	assign mode_wr = merge(pack_mode(mode), wb_dat_i, wb_sel_i);

	// ==========================================================
	// shutdown command pipeline
	logic       cmd_ok;
	logic [1:0] cmd_cnt;
	logic [1:0] next_cmd_cnt;
	logic       off;
	logic       next_off;
	logic       release_req;

	assign cmd_ok = wr && (wb_adr_i == SDWC_CMD_OFF) && (&wb_sel_i[3:0])
		&& (wb_dat_i[SDWC_KEY_LSB +: 8] == SDWC_WRITE_KEY_VALUE)
		&& wb_dat_i[SDWC_CMD_BIT];

	always_comb begin
		next_cmd_cnt = cmd_cnt;
		next_off = off;
		if (cmd_ok) begin
			next_cmd_cnt = SDWC_CMD_ONE;
		end else if (cmd_cnt == SDWC_CMD_LAST) begin
			next_cmd_cnt = 2'h0;
			next_off = 1'b1;
		end else if (cmd_cnt != 2'h0) begin
			next_cmd_cnt = cmd_cnt + SDWC_CMD_ONE;
		end
		if (release_req) begin
			next_off = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_cnt <= 2'h0;
			off <= 1'b0;
		end else begin
			cmd_cnt <= next_cmd_cnt;
			off <= next_off;
		end
	end

	// ==========================================================
	// wake input edge detect and debounce
	logic        wake_q;
	logic        alarm_q;
	logic        trig;
	logic        chg;
	logic        level;
	logic        next_level;
	logic [8:0]  deb;
	logic [8:0]  next_deb;
	logic [8:0]  target;
	logic        wake_done;
	logic        alarm_evt;
	sdwc_state_t st;
	sdwc_state_t next_st;

	assign chg = wake_input_pin_i != wake_q;
	always_comb begin
		case (mode.wake_edge_select)
			SDWC_RISE:         trig = chg && wake_input_pin_i;
			SDWC_WAKE_ON_FALL: trig = chg && !wake_input_pin_i;
			SDWC_ANY:          trig = chg;
			default:           trig = 1'b0;
		endcase
	end

	assign target = 9'({mode.wake_debounce_count, 4'h0}) + SDWC_DEB_ONE;

	always_comb begin
		next_st = st;
		next_deb = deb;
		next_level = level;
		wake_done = 1'b0;
		case (st)
			SDWC_IDLE: begin
				if (trig) begin
					next_st = SDWC_DEBOUNCE;
					next_deb = SDWC_DEB_ONE;
					next_level = wake_input_pin_i;
				end
			end
			SDWC_DEBOUNCE: begin
				if (mode.wake_edge_select == SDWC_NO_DETECT) begin
					next_st = SDWC_IDLE;
					next_deb = 9'h000;
				end else if (wake_input_pin_i != level) begin
					next_st = SDWC_IDLE;
					next_deb = 9'h000;
				end else if (deb >= target) begin
					wake_done = 1'b1;
					next_st = SDWC_IDLE;
					next_deb = 9'h000;
				end else begin
					next_deb = deb + SDWC_DEB_ONE;
				end
			end
			default: begin
				next_st = SDWC_IDLE;
				next_deb = 9'h000;
			end
		endcase
	end

	assign alarm_evt = mode.alarm_wake_enable && alarm_i && !alarm_q;
	assign release_req = wake_done || alarm_evt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_q <= 1'b0;
			alarm_q <= 1'b0;
			st <= SDWC_IDLE;
			deb <= 9'h000;
			level <= 1'b0;
		end else begin
			wake_q <= wake_input_pin_i;
			alarm_q <= alarm_i;
			st <= next_st;
			deb <= next_deb;
			level <= next_level;
		end
	end

	// ==========================================================
	// registers and bus answer
	always_comb begin
		next_mode = mode;
		next_mask = mask;
		next_stat = stat;
		if (wr && wb_adr_i == SDWC_MODE_OFF) begin
			next_mode.alarm_wake_enable = mode_wr[SDWC_ALARM_BIT];
			next_mode.wake_debounce_count = mode_wr[SDWC_DEB_LSB +: 4];
			next_mode.wake_edge_select = sdwc_edge_t'(mode_wr[SDWC_EDGE_LSB +: 2]);
		end
		if (wr && wb_adr_i == SDWC_MASK_OFF) begin
			next_mask = merge(mask, wb_dat_i, wb_sel_i) & SDWC_STAT_MASK;
		end
		if (rd_stat) begin
			next_stat = 32'h0;
		end
		if (wake_done) begin
			next_stat[SDWC_WAKE_FLAG_BIT] = 1'b1;
		end
		if (alarm_evt) begin
			next_stat[SDWC_ALARM_FLAG_BIT] = 1'b1;
		end
		next_ack = req && hit;
		next_err = req && !hit;
		next_dat = 32'h0;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				SDWC_MODE_OFF: next_dat = pack_mode(mode);
				SDWC_STAT_OFF: next_dat = stat;
				SDWC_MASK_OFF: next_dat = mask;
				default:       next_dat = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= sdwc_mode_t'({SDWC_MODE_RST[SDWC_ALARM_BIT],
				SDWC_MODE_RST[SDWC_DEB_LSB +: 4], SDWC_MODE_RST[SDWC_EDGE_LSB +: 2]});
			stat <= SDWC_STAT_RST;
			mask <= SDWC_MASK_RST;
			wb_dat_o <= 32'h0;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			mode <= next_mode;
			stat <= next_stat;
			mask <= next_mask;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
			wb_err_o <= next_err;
		end
	end

	assign power_off_pin_o = off;
	assign irq_o = |(stat & mask);
endmodule
`default_nettype wire

/* File: logic/sdwc_pkg.sv */
// package: register map, field layout and constants of the power-down controller
package sdwc_pkg;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] SDWC_CMD_OFF  = 8'h00;
	localparam logic [7:0] SDWC_MODE_OFF = 8'h04;
	localparam logic [7:0] SDWC_STAT_OFF = 8'h08;
	localparam logic [7:0] SDWC_MASK_OFF = 8'h0c;
	// ==========================================================
	// command fields
	localparam logic [7:0] SDWC_WRITE_KEY_VALUE = 8'ha5;
	localparam int         SDWC_KEY_LSB         = 24;
	localparam int         SDWC_CMD_BIT         = 0;
	// ==========================================================
	// mode fields and reset
	localparam int          SDWC_EDGE_LSB  = 0;
	localparam int          SDWC_DEB_LSB   = 4;
	localparam int          SDWC_ALARM_BIT = 17;
	localparam logic [31:0] SDWC_MODE_RST  = 32'h0000_0003;
	// ==========================================================
	// status fields
	localparam int          SDWC_WAKE_FLAG_BIT  = 0;
	localparam int          SDWC_ALARM_FLAG_BIT = 17;
	localparam logic [31:0] SDWC_STAT_MASK      = 32'h0002_0001;
	localparam logic [31:0] SDWC_STAT_RST       = 32'h0000_0000;
	localparam logic [31:0] SDWC_MASK_RST       = 32'h0000_0000;
	// ==========================================================
	// timing
	localparam int         SDWC_CMD_DELAY = 2;
	localparam int         SDWC_DEB_MULT  = 16;
	localparam logic [8:0] SDWC_DEB_ONE   = 9'h001;
	localparam logic [1:0] SDWC_CMD_ONE   = 2'h1;
	localparam logic [1:0] SDWC_CMD_LAST  = 2'h2;

	typedef enum logic [1:0] {
		SDWC_NO_DETECT = 2'h0,
		SDWC_RISE      = 2'h1,
		SDWC_WAKE_ON_FALL = 2'h2,
		SDWC_ANY       = 2'h3
	} sdwc_edge_t;

	typedef struct packed {
		logic       alarm_wake_enable;
		logic [3:0] wake_debounce_count;
		sdwc_edge_t wake_edge_select;
	} sdwc_mode_t;

	typedef enum {
		SDWC_IDLE,
		SDWC_DEBOUNCE
	} sdwc_state_t;
endpackage

/* File: testbench/sdwc_top_asserts.sv */
// checker: bus answers and command timing
`timescale 1ns/1ns
`default_nettype none
module sdwc_chk import sdwc_pkg::*; (
	input wire logic        clk_i,            // clock
	input wire logic        rst_i,            // reset
	input wire logic        wb_cyc_i,         // cycle
	input wire logic        wb_stb_i,         // strobe
	input wire logic        wb_we_i,          // write
	input wire logic [7:0]  wb_adr_i,         // address
	input wire logic [3:0]  wb_sel_i,         // lanes
	input wire logic [31:0] wb_dat_i,         // wdata
	input wire logic [31:0] wb_dat_o,         // rdata
	input wire logic        wb_ack_o,         // ack
	input wire logic        wb_err_o,         // error
	input wire logic        wake_input_pin_i, // wake
	input wire logic        alarm_i,          // alarm
	input wire logic        power_off_pin_o,  // off
	input wire logic        irq_o             // irq
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====================
	// bus answer
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_cmd;
		s_req ##0 wb_we_i && wb_adr_i == SDWC_CMD_OFF && wb_sel_i == 4'hf;
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("long err");
	a_req_answer: assert property (s_req |=> wb_ack_o != wb_err_o) else $error("no answer");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
	a_err_unmap: assert property (s_req ##0 wb_adr_i > SDWC_MASK_OFF |=> wb_err_o)
		else $error("no err");
	// ====================
	// command
	a_cmd_onset: assert property (
		s_cmd ##0 wb_dat_i[31:24] == SDWC_WRITE_KEY_VALUE && wb_dat_i[0]
		|-> ##[2:4] power_off_pin_o) else $error("no shutdown");
	a_bad_key: assert property (
		s_cmd ##0 (wb_dat_i[31:24] != SDWC_WRITE_KEY_VALUE || !wb_dat_i[0]) && !power_off_pin_o
		|=> !power_off_pin_o [*4]) else $error("bad key obeyed");
	a_off_cause: assert property (
		$rose(power_off_pin_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
		else $error("shutdown uncaused");
endmodule
`default_nettype wire

/* File: testbench/sdwc_btn.sv */
// partner model: wake-up push-button and alarm source
`timescale 1ns/1ns
`default_nettype none
module sdwc_btn (
	input  wire logic clk_i,  // clock
	output logic      wake_o, // wake level
	output logic      alarm_o // alarm level
);
	initial begin
		wake_o = 1'b0;
		alarm_o = 1'b0;
	end
	task automatic hold(input logic v, input int n);
		@(posedge clk_i) wake_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic ring();
		@(posedge clk_i) alarm_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		alarm_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: testbench/sdwc_top_bench.sv */
// testbench: registers, command, wake-up and alarm
`timescale 1ns/1ns
`default_nettype none
module sdwc_top_bench;
	import sdwc_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wd = 32'h0, dat, rd;
	logic        ack, err, wake, alarm, off, irq, er;
	int          n_fail = 0, samples_checked = 0, cyc_n = 0;
	always #4 clk_i = ~clk_i;
	sdwc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
		.wb_err_o(err), .wake_input_pin_i(wake), .alarm_i(alarm), .power_off_pin_o(off),
		.irq_o(irq));
	sdwc_btn btn (.clk_i(clk_i), .wake_o(wake), .alarm_o(alarm));
	task automatic check(input logic [31:0] seen, exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i) cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		// ack is read as it stood at the edge, before the design updates it
		do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
		rd = dat;
		er = err;
		cyc <= 1'b0;
	endtask
	task automatic t_off();
		wb(1, SDWC_CMD_OFF, {SDWC_WRITE_KEY_VALUE, 24'h1});
		@(negedge clk_i) check(off, 1'b0, "early");
		@(negedge clk_i) check(off, 1'b1, "off");
	endtask
	task automatic t_regs();
		wb(0, SDWC_MODE_OFF, 0);
		check(rd, SDWC_MODE_RST, "mode");
		wb(0, SDWC_STAT_OFF, 0);
		check(rd, SDWC_STAT_RST, "stat");
		wb(0, 8'h10, 0);
		check(er, 1'b1, "err");
		wb(1, SDWC_CMD_OFF, 32'h5a00_0001);
		wb(1, SDWC_CMD_OFF, {SDWC_WRITE_KEY_VALUE, 24'h0});
		repeat (3) @(negedge clk_i);
		check(off, 1'b0, "key");
	endtask
	task automatic t_deb();
		wb(1, SDWC_MODE_OFF, 32'h0000_0011);
		t_off();
		wb(0, SDWC_STAT_OFF, 0);
		btn.hold(1'b1, 8);
		btn.hold(1'b0, 4);
		@(negedge clk_i) check(off, 1'b1, "bounce");
		btn.hold(1'b1, 14);
		@(negedge clk_i) check(off, 1'b1, "deb early");
		btn.hold(1'b1, 8);
		@(negedge clk_i) check(off, 1'b0, "deb");
		wb(0, SDWC_STAT_OFF, 0);
		check(rd, 32'h1, "flag");
		wb(0, SDWC_STAT_OFF, 0);
		check(rd, 32'h0, "flag clr");
		btn.hold(1'b0, 2);
	endtask
	task automatic t_modes();
		for (int m = 3; m >= 0; m--) begin
			wb(1, SDWC_MODE_OFF, m);
			t_off();
			btn.hold(1'b1, 6);
			@(negedge clk_i) check(off, !m[0], "rise");
			btn.hold(1'b0, 6);
			@(negedge clk_i) check(off, m == 0, "fall");
		end
	endtask
	task automatic t_alarm();
		wb(1, SDWC_MODE_OFF, 32'h0);
		t_off();
		btn.ring();
		@(negedge clk_i) check(off, 1'b1, "alarm off");
		wb(1, SDWC_MASK_OFF, SDWC_STAT_MASK);
		wb(1, SDWC_MODE_OFF, 32'h0002_0000);
		btn.ring();
		@(negedge clk_i) check(off, 1'b0, "alarm");
		check(irq, 1'b1, "irq");
		wb(1, SDWC_MASK_OFF, 32'h0);
		@(negedge clk_i) check(irq, 1'b0, "irq mask");
		wb(1, SDWC_MASK_OFF, SDWC_STAT_MASK);
		wb(0, SDWC_STAT_OFF, 0);
		check(rd, 32'h0002_0000, "alarm flag");
		@(negedge clk_i) check(irq, 1'b0, "irq clr");
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_deb();
		t_modes();
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_alarm();
		stop_test();
	end
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			n_fail++;
			stop_test();
		end
	end
endmodule
bind sdwc_top sdwc_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.wake_input_pin_i(wake_input_pin_i), .alarm_i(alarm_i),
	.power_off_pin_o(power_off_pin_o), .irq_o(irq_o));
`default_nettype wire
